// ==== src/audio_clk_irq_pkg.sv ====
// constants, field layouts and carrier types for the audio clock divider
// and interrupt enable block; assumes a 32-bit apb bus and one clock.
//
// Behaviour
// - master mode bit clock equals input clock over two times divider plus one.
// - master clock divider one or more gives input clock over twice the field.
// - master clock divider zero passes the input clock straight to the codec.
// - left zero-cross flag with its enable set raises the interrupt.
// - right zero-cross flag with its enable raises the interrupt; clear enable blocks it.
// - transmit level below transmit threshold with enable set raises the interrupt.
// - transmit overflow flag with its enable set raises the interrupt.
// - transmit underflow flag with its enable set raises the interrupt.
// - receive level at or above threshold sets its flag; interrupts when enabled.
// - receive overflow drives the interrupt only while its enable is set.
// - reading an empty receive fifo sets underflow flag; interrupts when enabled.
// - sign change or all-zero next sample sets zero-cross flag; write one clears.
// - transmit fifo reports full at eight words, bounding threshold comparisons.
`default_nettype none

package audio_clk_irq_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] off_clock_divider = 8'h04;
  localparam logic [7:0] off_irq_enable = 8'h08;
  localparam logic [7:0] off_status = 8'h0C;
  localparam logic [7:0] off_threshold_ctrl = 8'h10;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int bclk_div_lsb = 8;
  localparam int mclk_div_lsb = 0;
  localparam int irq_en_hi_lsb = 8;
  localparam int irq_en_lo_lsb = 0;
  localparam int tx_th_lsb = 0;
  localparam int rx_th_lsb = 4;
  localparam int master_mode_bit = 8;
  localparam int st_tx_level_lsb = 28;
  localparam int st_rx_level_lsb = 24;
  localparam logic [31:0] clock_divider_rst = 32'h0000_0000;
  localparam logic [31:0] irq_enable_rst = 32'h0000_0000;
  localparam logic [31:0] threshold_ctrl_rst = 32'h0000_0000;
  localparam logic [3:0] fifo_full_words = 4'h8;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  // order matches enable bits 12..8 then 2..0
  typedef struct packed {
    logic left_zc;
    logic right_zc;
    logic tx_th;
    logic tx_ovf;
    logic tx_udf;
    logic rx_th;
    logic rx_ovf;
    logic rx_udf;
  } irq_flags_t;

  typedef struct packed {
    logic [3:0] tx_level;
    logic [3:0] rx_level;
    logic tx_overflow;
    logic tx_underflow;
    logic rx_overflow;
    logic rx_fifo_read;
  } fifo_status_t;

endpackage

`default_nettype wire

// ==== src/audio_clk_irq.sv ====
// clock divider and interrupt enable logic of an i2s audio controller.
// fifo levels, fifo events and channel samples come from logic on pclk;
// the codec master clock bypass is muxed onto the pad outside this block.
`default_nettype none

module audio_clk_irq #(
  parameter int sample_width = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo datapath status
  input wire audio_clk_irq_pkg::fifo_status_t fifo_st,
  // channel samples, index 1 left, index 0 right
  input wire logic [1:0] sample_valid,
  input wire logic [1:0][sample_width-1:0] sample_data,
  // codec clocks
  output logic mclk,
  output logic mclk_bypass,
  output logic bclk,
  output logic bclk_tick,
  // fifo full report and interrupt
  output logic tx_full,
  output logic irq
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic [31:0] clkdiv_q;
  logic [31:0] irq_en_q;
  logic [31:0] thctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  audio_clk_irq_pkg::irq_flags_t flags_q;
  audio_clk_irq_pkg::irq_flags_t flags_d;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire sel_div = paddr == audio_clk_irq_pkg::off_clock_divider;
  wire sel_ien = paddr == audio_clk_irq_pkg::off_irq_enable;
  wire sel_st = paddr == audio_clk_irq_pkg::off_status;
  wire sel_th = paddr == audio_clk_irq_pkg::off_threshold_ctrl;
  wire mapped = sel_div || sel_ien || sel_st || sel_th;
  wire wr_div = access && pwrite && sel_div;
  wire wr_ien = access && pwrite && sel_ien;
  wire wr_st = access && pwrite && sel_st;
  wire wr_th = access && pwrite && sel_th;

  // ----------------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------------
  wire [7:0] bclk_div = clkdiv_q[audio_clk_irq_pkg::bclk_div_lsb +: 8];
  wire [2:0] mclk_div = clkdiv_q[audio_clk_irq_pkg::mclk_div_lsb +: 3];
  wire [2:0] tx_th_level = thctrl_q[audio_clk_irq_pkg::tx_th_lsb +: 3];
  wire [2:0] rx_th_level = thctrl_q[audio_clk_irq_pkg::rx_th_lsb +: 3];
  wire master_mode = thctrl_q[audio_clk_irq_pkg::master_mode_bit];
  wire audio_clk_irq_pkg::irq_flags_t irq_en = {
    irq_en_q[audio_clk_irq_pkg::irq_en_hi_lsb +: 5],
    irq_en_q[audio_clk_irq_pkg::irq_en_lo_lsb +: 3]};

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_q <= audio_clk_irq_pkg::clock_divider_rst;
      irq_en_q <= audio_clk_irq_pkg::irq_enable_rst;
      thctrl_q <= audio_clk_irq_pkg::threshold_ctrl_rst;
    end else begin
      if (wr_div) clkdiv_q <= pwdata & 32'h0000_FF07;
      if (wr_ien) irq_en_q <= pwdata & 32'h0000_1F07;
      if (wr_th) thctrl_q <= pwdata & 32'h0000_0177;
    end
  end

  // ----------------------------------------------------------------------
  // master clock divider
  // ----------------------------------------------------------------------
  logic [2:0] mclk_cnt_q;
  logic mclk_q;
  logic mclk_bypass_q;
  wire mclk_wrap = mclk_cnt_q >= mclk_div - 3'h1;

  // half period of mclk_div input cycles gives input over twice the field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_cnt_q <= 3'h0;
      mclk_q <= 1'b0;
      mclk_bypass_q <= 1'b1;
    end else begin
      mclk_bypass_q <= mclk_div == 3'h0;
      if (mclk_div == 3'h0) begin
        mclk_cnt_q <= 3'h0;
        mclk_q <= 1'b0;
      end else if (mclk_wrap) begin
        mclk_cnt_q <= 3'h0;
        mclk_q <= !mclk_q;
      end else begin
        mclk_cnt_q <= mclk_cnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bit clock divider
  // ----------------------------------------------------------------------
  logic [7:0] bclk_cnt_q;
  logic bclk_q;
  logic bclk_tick_q;
  wire bclk_wrap = bclk_cnt_q >= bclk_div;

  // toggling every bclk_div+1 cycles; a divider rewrite takes effect at once,
  // so a value below the running count wraps early and can drive a runt pulse toward the codec
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_cnt_q <= 8'h00;
      bclk_q <= 1'b0;
      bclk_tick_q <= 1'b0;
    end else if (!master_mode) begin
      bclk_cnt_q <= 8'h00;
      bclk_q <= 1'b0;
      bclk_tick_q <= 1'b0;
    end else if (bclk_wrap) begin
      bclk_cnt_q <= 8'h00;
      bclk_q <= !bclk_q;
      bclk_tick_q <= !bclk_q;
    end else begin
      bclk_cnt_q <= bclk_cnt_q + 8'h01;
      bclk_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // zero-cross detection per channel
  // ----------------------------------------------------------------------
  logic [1:0] zc_hit;
  logic [1:0] sign_q;

  for (genvar ch = 0; ch < 2; ch++) begin : g_zc
    wire sgn = sample_data[ch][sample_width-1];
    assign zc_hit[ch] = sample_valid[ch] &&
      (sample_data[ch] == '0 || sgn != sign_q[ch]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sign_q[ch] <= 1'b0;
      else if (sample_valid[ch]) sign_q[ch] <= sgn;
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags, write one to clear, set wins over clear
  // ----------------------------------------------------------------------
  // levels above eight words are clamped so a glitching datapath cannot
  // satisfy a threshold the fifo could never reach
  wire [3:0] tx_lvl = fifo_st.tx_level > audio_clk_irq_pkg::fifo_full_words ?
    audio_clk_irq_pkg::fifo_full_words : fifo_st.tx_level;
  wire [3:0] rx_lvl = fifo_st.rx_level > audio_clk_irq_pkg::fifo_full_words ?
    audio_clk_irq_pkg::fifo_full_words : fifo_st.rx_level;
  wire audio_clk_irq_pkg::irq_flags_t set_ev = {
    zc_hit[1],
    zc_hit[0],
    tx_lvl < {1'b0, tx_th_level},
    fifo_st.tx_overflow,
    fifo_st.tx_underflow,
    rx_lvl >= {1'b0, rx_th_level},
    fifo_st.rx_overflow,
    fifo_st.rx_fifo_read && rx_lvl == 4'h0};
  wire audio_clk_irq_pkg::irq_flags_t clr_ev = wr_st ? {
    pwdata[23], pwdata[22], pwdata[18], pwdata[17], pwdata[16],
    pwdata[10], pwdata[9], pwdata[8]} : '0;

  assign flags_d = set_ev | (flags_q & ~clr_ev);

  // ----------------------------------------------------------------------
  // interrupt, fifo full report
  // ----------------------------------------------------------------------
  wire audio_clk_irq_pkg::irq_flags_t pend = flags_q & irq_en;
  wire irq_d = |pend;
  logic irq_q;
  logic tx_full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
      irq_q <= 1'b0;
      tx_full_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q <= irq_d;
      tx_full_q <= tx_lvl == audio_clk_irq_pkg::fifo_full_words;
    end
  end

  // ----------------------------------------------------------------------
  // read mux and apb answer
  // ----------------------------------------------------------------------
  wire tx_pend = pend.tx_th || pend.tx_ovf || pend.tx_udf;
  wire rx_pend = pend.rx_th || pend.rx_ovf || pend.rx_udf;
  wire [31:0] status_word = {
    tx_lvl, rx_lvl,
    flags_q.left_zc, flags_q.right_zc, 1'b0, tx_lvl == 4'h0,
    tx_lvl == audio_clk_irq_pkg::fifo_full_words,
    flags_q.tx_th, flags_q.tx_ovf, flags_q.tx_udf,
    4'h0, rx_lvl == audio_clk_irq_pkg::fifo_full_words,
    flags_q.rx_th, flags_q.rx_ovf, flags_q.rx_udf,
    5'h00, tx_pend, rx_pend, |pend};
  wire [31:0] rd_word = sel_div ? clkdiv_q :
    sel_ien ? irq_en_q :
    sel_st ? status_word :
    sel_th ? thctrl_q : 32'h0000_0000;

  // answer in the access phase, one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_q <= !mapped;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mclk = mclk_q;
  assign mclk_bypass = mclk_bypass_q;
  assign bclk = bclk_q;
  assign bclk_tick = bclk_tick_q;
  assign tx_full = tx_full_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bclk_edge;
    master_mode && bclk_wrap && !wr_div && !wr_th;
  endsequence

  // overflow and underflow take two steps: pulse to flag, flag to irq
  sequence s_tx_ovf_ev;
    fifo_st.tx_overflow && irq_en.tx_ovf && !wr_ien;
  endsequence

  sequence s_tx_udf_ev;
    fifo_st.tx_underflow && irq_en.tx_udf && !wr_ien;
  endsequence

  a_zero_wait: assert property (
    setup |=> pready_q)
    else $error("apb answer not ready after setup");
  a_unmapped_err: assert property (
    setup && !mapped |=> pslverr_q)
    else $error("unmapped address gave no error");
  a_bclk_toggle: assert property (
    s_bclk_edge |=> bclk_q != $past(bclk_q))
    else $error("bit clock missed its toggle");
  a_bclk_steady: assert property (
    master_mode && !bclk_wrap && !wr_th |=> $stable(bclk_q))
    else $error("bit clock toggled early");
  a_bclk_tick_rise: assert property (
    bclk_tick_q |-> bclk_q && !$past(bclk_q))
    else $error("bit clock tick off its rising edge");
  a_bclk_idle: assert property (
    !master_mode |=> !bclk_q)
    else $error("bit clock ran outside master mode");
  a_mclk_toggle: assert property (
    mclk_div != 3'h0 && mclk_wrap && !wr_div |=> mclk_q != $past(mclk_q))
    else $error("master clock missed its toggle");
  a_mclk_steady: assert property (
    mclk_div != 3'h0 && !mclk_wrap |=> $stable(mclk_q))
    else $error("master clock toggled early");
  a_mclk_bypass_on: assert property (
    mclk_div == 3'h0 |=> mclk_bypass_q)
    else $error("master clock bypass not selected");
  a_mclk_held: assert property (
    mclk_div == 3'h0 |=> !mclk_q)
    else $error("divided master clock ran in bypass");
  a_left_zc_irq: assert property (
    flags_q.left_zc && irq_en.left_zc |=> irq_q)
    else $error("left zero cross did not interrupt");
  a_right_zc_irq: assert property (
    flags_q.right_zc && irq_en.right_zc |=> irq_q)
    else $error("right zero cross did not interrupt");
  a_right_zc_block: assert property (
    !irq_en.right_zc && flags_q == 8'h40 |=> !irq_q)
    else $error("blocked source raised interrupt");
  a_tx_th_flag: assert property (
    tx_lvl < {1'b0, tx_th_level} |=> flags_q.tx_th)
    else $error("transmit threshold flag not set");
  a_tx_th_irq: assert property (
    flags_q.tx_th && irq_en.tx_th |=> irq_q)
    else $error("transmit threshold did not interrupt");
  a_tx_ovf_irq: assert property (
    s_tx_ovf_ev |=> ##1 irq_q)
    else $error("transmit overflow did not interrupt");
  a_tx_udf_irq: assert property (
    s_tx_udf_ev |=> ##1 irq_q)
    else $error("transmit underflow did not interrupt");
  a_rx_th_flag: assert property (
    rx_lvl >= {1'b0, rx_th_level} |=> flags_q.rx_th)
    else $error("receive threshold flag not set");
  a_rx_th_irq: assert property (
    flags_q.rx_th && irq_en.rx_th |=> irq_q)
    else $error("receive threshold did not interrupt");
  a_rx_ovf_irq: assert property (
    flags_q.rx_ovf && irq_en.rx_ovf |=> irq_q)
    else $error("receive overflow did not interrupt");
  a_rx_ovf_gate: assert property (
    !irq_en.rx_ovf && flags_q == 8'h02 |=> !irq_q)
    else $error("receive overflow leaked while disabled");
  a_rx_udf_set: assert property (
    fifo_st.rx_fifo_read && rx_lvl == 4'h0 |=> flags_q.rx_udf)
    else $error("empty read did not set underflow");
  a_rx_udf_irq: assert property (
    flags_q.rx_udf && irq_en.rx_udf |=> irq_q)
    else $error("receive underflow did not interrupt");
  a_zc_set: assert property (
    zc_hit[0] |=> flags_q.right_zc)
    else $error("zero cross flag not set");
  a_zc_clear: assert property (
    wr_st && pwdata[23] && !zc_hit[1] |=> !flags_q.left_zc)
    else $error("zero cross flag not cleared");
  a_tx_full_rep: assert property (
    tx_lvl == 4'h8 |=> tx_full_q)
    else $error("full not reported at eight words");
  a_tx_full_low: assert property (
    tx_lvl != 4'h8 |=> !tx_full_q)
    else $error("full reported below eight words");
  a_irq_hold: assert property (
    irq_q && pend != 8'h00 |=> irq_q)
    else $error("interrupt dropped while pending");
  a_irq_quiet: assert property (
    pend == 8'h00 |=> !irq_q)
    else $error("interrupt raised with nothing pending");

endmodule

`default_nettype wire

// ==== test/codec_model.sv ====
// codec side listener: measures the master and bit clock periods it sees.
// assumes both clocks are launched from pclk flops, so pclk can time them.
`default_nettype none
module codec_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // clocks from the controller
  input wire logic mclk,
  input wire logic bclk,
  // last measured periods, in pclk cycles
  output logic [31:0] mclk_period,
  output logic [31:0] bclk_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_q, bclk_q;
  logic [31:0] mcnt_q, bcnt_q;
  wire mrise = mclk && !mclk_q;
  wire brise = bclk && !bclk_q;
  // codec needs a 256fs master clock, so only its period matters here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mclk_q, bclk_q} <= 2'h0;
      {mcnt_q, bcnt_q, mclk_period, bclk_period} <= '0;
    end else begin
      mclk_q <= mclk;
      bclk_q <= bclk;
      mcnt_q <= mrise ? 32'h1 : mcnt_q + 32'h1;
      bcnt_q <= brise ? 32'h1 : bcnt_q + 32'h1;
      if (mrise) mclk_period <= mcnt_q;
      if (brise) bclk_period <= bcnt_q;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the audio clock divider and interrupt block.
// polls pready for any wait-state count and assumes the codec listener beside it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata, v;
  logic pready, pslverr, rerr;
  audio_clk_irq_pkg::fifo_status_t fifo_st = '0;
  logic [1:0] sample_valid = 2'h0;
  logic [1:0][31:0] sample_data = '0;
  logic mclk, mclk_bypass, bclk, bclk_tick, tx_full, irq;
  logic [31:0] mclk_period, bclk_period;
  logic [7:0] b;
  int errors = 0, n_tests = 0;

  always #4 pclk = ~pclk;

  audio_clk_irq audio_clk_irq_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_st(fifo_st), .sample_valid(sample_valid),
    .sample_data(sample_data), .mclk(mclk), .mclk_bypass(mclk_bypass),
    .bclk(bclk), .bclk_tick(bclk_tick), .tx_full(tx_full), .irq(irq));

  codec_model codec_model_inst (.pclk(pclk), .presetn(presetn),
    .mclk(mclk), .bclk(bclk), .mclk_period(mclk_period),
    .bclk_period(bclk_period));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // no wait-state count assumed: the watchdog bounds the pready wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // enable and status positions of source k, in irq_flags_t order
  function automatic logic [31:0] en_m(input int k);
    return 32'h1 << (k < 5 ? 12 - k : 7 - k);
  endfunction

  function automatic logic [31:0] st_m(input int k);
    return 32'h1 << (k < 2 ? 23 - k : (k < 5 ? 20 - k : 15 - k));
  endfunction

  task automatic cause(input int k);
    @(posedge pclk);
    case (k)
      0: sample_valid <= 2'h2;
      1: sample_valid <= 2'h1;
      2: fifo_st.tx_level <= 4'($urandom_range(4, 0));
      3: fifo_st.tx_overflow <= 1'b1;
      4: fifo_st.tx_underflow <= 1'b1;
      5: fifo_st.rx_level <= 4'h7;
      6: fifo_st.rx_overflow <= 1'b1;
      default: fifo_st.rx_fifo_read <= 1'b1;
    endcase
    @(posedge pclk);
    sample_valid <= 2'h0;
    fifo_st[3:0] <= 4'h0;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    ticks(5000);
    errors++;
    end_of_test;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    v = $urandom(9367);
    ticks(6);
    presetn <= 1'b1;
    ticks(1);
    apb(1'b0, 8'h04, 32'h0);
    check_word(rdata, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check_word(rdata, 32'h0);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    check_bit(rerr, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check_bit(rerr, 1'b1);
    check_word(rdata, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      apb(1'b1, 8'h04, v);
      apb(1'b0, 8'h04, 32'h0);
      check_word(rdata, v & 32'h0000_FF07);
      apb(1'b1, 8'h08, v);
      apb(1'b0, 8'h08, 32'h0);
      check_word(rdata, v & 32'h0000_1F07);
    end
    $display("done: registers");
    // master mode, tx threshold 5, rx threshold 7
    apb(1'b1, 8'h10, 32'h175);
    for (int m = 0; m < 8; m++) begin
      b = (m == 1) ? 8'h00 : (m == 7 ? 8'hFF : 8'($urandom_range(15, 0)));
      apb(1'b1, 8'h04, {16'h0, b, 5'h0, 3'(m)});
      ticks(4 * (b + 1) + 40);
      check_word(bclk_period, 32'(2 * (b + 1)));
      do @(posedge pclk); while (bclk_tick !== 1'b1);
      check_bit(bclk, 1'b1);
      ticks(1);
      check_bit(bclk_tick, 1'b0);
      if (m == 0) begin
        check_bit(mclk_bypass, 1'b1);
        check_bit(mclk, 1'b0);
      end else
        check_word(mclk_period, 32'(2 * m));
    end
    apb(1'b1, 8'h10, 32'h75);
    ticks(4);
    check_bit(bclk, 1'b0);
    $display("done: clocks");
    fifo_st.tx_level <= 4'h8;
    ticks(2);
    check_bit(tx_full, 1'b1);
    fifo_st.tx_level <= 4'h7;
    ticks(2);
    check_bit(tx_full, 1'b0);
    fifo_st.tx_level <= 4'h5;
    $display("done: full flag");
    apb(1'b1, 8'h0C, 32'h00C7_0700);
    apb(1'b1, 8'h08, 32'h1F07);
    // positive non-zero samples must not look like a zero cross
    for (int i = 0; i < 4; i++) begin
      v = $urandom | 32'h1;
      @(posedge pclk);
      sample_data <= {{1'b0, v[30:0]}, {1'b0, v[30:0]}};
      sample_valid <= 2'h3;
      @(posedge pclk);
      sample_valid <= 2'h0;
    end
    ticks(3);
    check_bit(irq, 1'b0);
    sample_data <= '0;
    for (int k = 0; k < 8; k++) begin
      cause(k);
      ticks(3);
      check_bit(irq, 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      check_word(rdata & st_m(k), st_m(k));
      apb(1'b1, 8'h08, 32'h1F07 & ~en_m(k));
      ticks(2);
      check_bit(irq, 1'b0);
      if (k == 2) fifo_st.tx_level <= 4'h5;
      if (k == 5) fifo_st.rx_level <= 4'h0;
      apb(1'b1, 8'h0C, st_m(k));
      apb(1'b1, 8'h08, 32'h1F07);
      ticks(2);
      check_bit(irq, 1'b0);
    end
    $display("done: interrupts");
    end_of_test;
  end
endmodule
`default_nettype wire
